// [bench/ipe_controller_tb_top.sv]
`timescale 1ns/1ps
module ipe_controller_tb_top
    import ipe_pkg::*;
;
    logic              clk_in = 1'b0;
    logic              srst_in = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0]        reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        rdata;
    logic [7:0]        g0_req = '0;
    logic [7:0]        pins = '0;
    logic              cmp_req = 1'b0;
    logic              dbg_req = 1'b0;
    logic [7:0]        per_req = '0;
    logic              gl_en = 1'b0;
    logic              ack;
    logic              irq_req;
    logic [SRC_W-1:0]  irq_src;
    logic [LVL_W-1:0]  irq_lvl;
    logic [3:0]        delay = 4'h0;
    logic              rd_d = 1'b0;
    logic [7:0]        rd_q[$];
    logic [7:0]        irq_q[$];
    int                bad_count = 0;
    int                n_compared = 0;
    int                seed = 32'h2e18b41b;
    logic [7:0]        s, m, p, h, l;
    logic [ADDR_W-1:0] addrs[10] = '{ADDR_G0_PEND, ADDR_G0_SET, ADDR_G0_ENH, ADDR_G0_ENL,
        ADDR_PP_PEND, ADDR_PP_SET, ADDR_PER_PEND, ADDR_PER_SET, ADDR_MUX_SEL, 24'hffe03f};

    always #4 clk_in = ~clk_in;

    ipe_controller dut_u (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .group0_req_in(g0_req), .port_pin_in(pins),
        .comparator_req_in(cmp_req), .debugger_req_in(dbg_req), .peripheral_req_in(per_req),
        .global_enable_in(gl_en), .irq_ack_in(ack), .irq_req_out(irq_req),
        .irq_source_out(irq_src), .irq_level_out(irq_lvl));

    ipe_core_model core_u (.clk_in(clk_in), .srst_in(srst_in), .auto_ack_in(1'b1),
        .delay_in(delay), .irq_req_in(irq_req), .irq_ack_out(ack));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(posedge clk_in);
    endtask

    // clear-by-one and set companion on one pending register
    task automatic w1c_case(input logic [ADDR_W-1:0] pa, input logic [ADDR_W-1:0] sa);
        s = 8'($random(seed));
        m = 8'($random(seed));
        wr(sa, s);
        wr(sa, 8'h00);
        rd(pa, s);
        rd(sa, RD_ZERO);
        wr(pa, m);
        rd(pa, s & ~m);
        wr(pa, 8'hff);
        rd(pa, 8'h00);
    endtask

    // results are compared in order of appearance against the oldest note
    always @(posedge clk_in) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            if (rd_q.size() == 0) check("stray read", 8'hee, rdata);
            else check("read data", rd_q.pop_front(), rdata);
        end
        if (ack === 1'b1 && irq_req === 1'b1) begin
            if (irq_q.size() == 0) check("stray irq", 8'hee, {3'b000, irq_src, irq_lvl});
            else check("irq pick", irq_q.pop_front(), {3'b000, irq_src, irq_lvl});
        end
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        w1c_case(ADDR_PP_PEND, ADDR_PP_SET);
        w1c_case(ADDR_PER_PEND, ADDR_PER_SET);
        w1c_case(ADDR_G0_PEND, ADDR_G0_SET);
        s = 8'($random(seed));
        per_req <= s;
        @(posedge clk_in);
        per_req <= 8'h00;
        @(posedge clk_in);
        rd(ADDR_PER_PEND, s);
        wr(ADDR_PER_PEND, 8'hff);
        for (int n = 0; n < 8; n++) begin
            repeat (2) begin
                // each edge of the pin sets the flag, rising then falling
                pins <= pins ^ (8'h01 << n);
                repeat (6) @(posedge clk_in);
                rd(ADDR_PP_PEND, 8'h01 << n);
                wr(ADDR_PP_PEND, 8'h01 << n);
            end
        end
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_MUX_SEL, k ? 8'h81 : 8'h00);
            rd(ADDR_MUX_SEL, k ? 8'h81 : 8'h00);
            cmp_req <= 1'b1;
            dbg_req <= 1'b1;
            @(posedge clk_in);
            cmp_req <= 1'b0;
            dbg_req <= 1'b0;
            @(posedge clk_in);
            rd(ADDR_PP_PEND, k ? 8'h81 : 8'h00);
            wr(ADDR_PP_PEND, 8'hff);
        end
        for (int r = 0; r < 4; r++) begin
            p = 8'($random(seed));
            h = 8'($random(seed));
            l = 8'($random(seed));
            wr(ADDR_G0_ENH, h);
            wr(ADDR_G0_ENL, l);
            rd(ADDR_G0_ENH, h);
            rd(ADDR_G0_ENL, l);
            g0_req <= p;
            @(posedge clk_in);
            g0_req <= 8'h00;
            repeat (4) @(posedge clk_in);
            rd(ADDR_G0_PEND, p);
            for (int lv = 3; lv > 0; lv--) begin
                for (int b = 7; b >= 0; b--) begin
                    if (p[b] && {h[b], l[b]} == lv[1:0]) irq_q.push_back({3'b000, b[2:0], lv[1:0]});
                end
            end
            delay <= r[3:0];
            gl_en <= 1'b1;
            for (int t = 0; t < 300 && irq_q.size() > 0; t++) @(posedge clk_in);
            check("irq queue left", 8'h00, 8'(irq_q.size()));
            repeat (4) @(posedge clk_in);
            gl_en <= 1'b0;
            @(posedge clk_in);
            // acked bits are gone, disabled sources stay pending
            rd(ADDR_G0_PEND, p & ~(h | l));
            wr(ADDR_G0_PEND, 8'hff);
        end
        wr(ADDR_PP_SET, 8'h5a);
        srst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        rd(ADDR_PP_PEND, 8'h00);
        repeat (3) @(posedge clk_in);
        tally_and_finish();
    end
endmodule

// [bench/ipe_core_model.sv]
`timescale 1ns/1ps
// core side: takes a vectored request after a chosen wait, acks with one pulse
module ipe_core_model (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       auto_ack_in,
    input  wire logic [3:0] delay_in,
    input  wire logic       irq_req_in,
    output logic            irq_ack_out
);
    logic [3:0] wait_cnt;

    always @(posedge clk_in) begin
        // polled mode: the core never acks, software reads the flags instead
        if (srst_in || !auto_ack_in) begin
            irq_ack_out <= 1'b0;
            wait_cnt    <= 4'h0;
        end else if (irq_ack_out) begin
            // request drops for a cycle after an ack, so start counting afresh
            irq_ack_out <= 1'b0;
            wait_cnt    <= 4'h0;
        end else if (irq_req_in) begin
            if (wait_cnt >= delay_in) begin
                irq_ack_out <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// [verilog/ipe_controller.sv]
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - source request sets pending bit, held
// - globally enabled: forward pending enabled requests
// - writing one to pending clears bit
// - port-pin pending has write-only set companion
// - peripheral pending has write-only set companion
// - port-pin bit n flags pin n
// - port-pin bit set on either pin edge
// - pending setting ignores enable bits
// - bit 7 may take comparator request
// - bit 0 may take debugger request
// - peripheral bits map fixed peripheral sources
// - two enable bits give off or level
// - enable bits follow group0 pending order
// - acknowledge clears source pending bit
// - group0 pending with set companion
module ipe_controller
    import ipe_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [DATA_W-1:0] reg_rdata_out,
    input  wire logic [DATA_W-1:0] group0_req_in,
    input  wire logic [DATA_W-1:0] port_pin_in,
    input  wire logic              comparator_req_in,
    input  wire logic              debugger_req_in,
    input  wire logic [DATA_W-1:0] peripheral_req_in,
    input  wire logic              global_enable_in,
    input  wire logic              irq_ack_in,
    output logic                   irq_req_out,
    output logic      [SRC_W-1:0]  irq_source_out,
    output logic      [LVL_W-1:0]  irq_level_out
);
    logic [DATA_W-1:0] group0_pending;
    logic [DATA_W-1:0] group0_enable_high;
    logic [DATA_W-1:0] group0_enable_low;
    logic [DATA_W-1:0] port_pin_pending;
    logic [DATA_W-1:0] peripheral_pending;
    logic [DATA_W-1:0] mux_select;

    logic              wr_g0_pend;
    logic              wr_g0_set;
    logic              wr_g0_enh;
    logic              wr_g0_enl;
    logic              wr_pp_pend;
    logic              wr_pp_set;
    logic              wr_per_pend;
    logic              wr_per_set;
    logic              wr_mux;

    logic [DATA_W-1:0] pin_toggle;
    logic [DATA_W-1:0] pp_hw;
    logic [DATA_W-1:0] g0_set;
    logic [DATA_W-1:0] g0_clr;
    logic [DATA_W-1:0] pp_set;
    logic [DATA_W-1:0] pp_clr;
    logic [DATA_W-1:0] per_set;
    logic [DATA_W-1:0] per_clr;
    logic [DATA_W-1:0] ack_mask;
    logic              ack_take;
    logic [DATA_W-1:0] rd_mux;

    logic              pick_valid;
    logic [SRC_W-1:0]  pick_idx;
    logic [LVL_W-1:0]  pick_level;

    // register decode
    assign wr_g0_pend  = reg_wr_in && (reg_addr_in == ADDR_G0_PEND);
    assign wr_g0_set   = reg_wr_in && (reg_addr_in == ADDR_G0_SET);
    assign wr_g0_enh   = reg_wr_in && (reg_addr_in == ADDR_G0_ENH);
    assign wr_g0_enl   = reg_wr_in && (reg_addr_in == ADDR_G0_ENL);
    assign wr_pp_pend  = reg_wr_in && (reg_addr_in == ADDR_PP_PEND);
    assign wr_pp_set   = reg_wr_in && (reg_addr_in == ADDR_PP_SET);
    assign wr_per_pend = reg_wr_in && (reg_addr_in == ADDR_PER_PEND);
    assign wr_per_set  = reg_wr_in && (reg_addr_in == ADDR_PER_SET);
    assign wr_mux      = reg_wr_in && (reg_addr_in == ADDR_MUX_SEL);

    // pins come from outside this clock, so they are synchronised first
    ipe_edge_sync #(
        .W (DATA_W)
    ) u_pin_sync (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .pin_in     (port_pin_in),
        .toggle_out (pin_toggle)
    );

    // bit n follows pin n; ends may be switched to comparator/debugger
    assign pp_hw = {mux_select[MUX_COMPARATOR_BIT] ? comparator_req_in
                                                   : pin_toggle[7],
                    pin_toggle[6:1],
                    mux_select[MUX_DEBUGGER_BIT] ? debugger_req_in
                                                 : pin_toggle[0]};

    // acknowledge only counts while a request is shown
    assign ack_take = irq_ack_in && irq_req_out;
    assign ack_mask = ack_take ? (8'h01 << irq_source_out) : RD_ZERO;

    // enables take no part in setting pending bits
    assign g0_set  = group0_req_in | (wr_g0_set ? reg_wdata_in : RD_ZERO);
    assign g0_clr  = (wr_g0_pend ? reg_wdata_in : RD_ZERO) | ack_mask;
    assign pp_set  = pp_hw | (wr_pp_set ? reg_wdata_in : RD_ZERO);
    assign pp_clr  = wr_pp_pend ? reg_wdata_in : RD_ZERO;
    // bit 7 pwm timer, 6 uart1 rx, 5 uart1 tx, 4 pwm fault, 3..0 port c or dma
    assign per_set = peripheral_req_in | (wr_per_set ? reg_wdata_in : RD_ZERO);
    assign per_clr = wr_per_pend ? reg_wdata_in : RD_ZERO;

    // pending bits hold until cleared; zeros written change nothing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            group0_pending     <= PEND_RST;
            port_pin_pending   <= PEND_RST;
            peripheral_pending <= PEND_RST;
        end else begin
            group0_pending     <= ipe_next_pending(group0_pending, g0_set, g0_clr);
            port_pin_pending   <= ipe_next_pending(port_pin_pending, pp_set, pp_clr);
            peripheral_pending <= ipe_next_pending(peripheral_pending, per_set, per_clr);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            group0_enable_high <= EN_RST;
            group0_enable_low  <= EN_RST;
            mux_select         <= MUX_RST;
        end else begin
            if (wr_g0_enh) begin
                group0_enable_high <= reg_wdata_in;
            end
            if (wr_g0_enl) begin
                group0_enable_low <= reg_wdata_in;
            end
            if (wr_mux) begin
                mux_select <= reg_wdata_in;
            end
        end
    end

    // set companions and unmapped addresses read as zero
    assign rd_mux = (reg_addr_in == ADDR_G0_PEND)  ? group0_pending     :
                    (reg_addr_in == ADDR_G0_ENH)   ? group0_enable_high :
                    (reg_addr_in == ADDR_G0_ENL)   ? group0_enable_low  :
                    (reg_addr_in == ADDR_PP_PEND)  ? port_pin_pending   :
                    (reg_addr_in == ADDR_PER_PEND) ? peripheral_pending :
                    (reg_addr_in == ADDR_MUX_SEL)  ? mux_select         :
                    RD_ZERO;

    // read data stand for one cycle only; polling uses this path
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= RD_ZERO;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : RD_ZERO;
        end
    end

    ipe_prio_pick #(
        .N (DATA_W)
    ) u_pick (
        .pend_in   (group0_pending),
        .enh_in    (group0_enable_high),
        .enl_in    (group0_enable_low),
        .valid_out (pick_valid),
        .idx_out   (pick_idx),
        .level_out (pick_level)
    );

    // the request drops for the cycle after an acknowledge so the same
    // source is never taken twice before its pending bit has cleared
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_req_out    <= 1'b0;
            irq_source_out <= '0;
            irq_level_out  <= IPE_LVL_OFF;
        end else begin
            irq_req_out    <= global_enable_in && pick_valid && !ack_take;
            irq_source_out <= pick_idx;
            irq_level_out  <= pick_level;
        end
    end

    // checks on the pending, forwarding and bus logic

    AST_HW_SET: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (|group0_req_in) |=>
            ((group0_pending & $past(group0_req_in)) == $past(group0_req_in)))
        else $error("group0 request did not set its pending bit");

    AST_W1C: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_pp_pend && (pp_set & reg_wdata_in) == RD_ZERO) |=>
            ((port_pin_pending & $past(reg_wdata_in)) == RD_ZERO))
        else $error("write one did not clear port-pin pending");

    AST_HOLD: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (g0_clr == RD_ZERO) |=>
            ((group0_pending & $past(group0_pending)) == $past(group0_pending)))
        else $error("group0 pending bit lost without a clear");

    AST_PP_SETREG: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_pp_set |=>
            ((port_pin_pending & $past(reg_wdata_in)) == $past(reg_wdata_in)))
        else $error("port-pin set write did not set pending");

    AST_PER_SETREG: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_per_set |=>
            ((peripheral_pending & $past(reg_wdata_in)) == $past(reg_wdata_in)))
        else $error("peripheral set write did not set pending");

    AST_TOGGLE: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (pin_toggle[3] && !wr_pp_pend) |=> port_pin_pending[3])
        else $error("pin toggle did not set pending bit 3");

    AST_FWD: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (global_enable_in && pick_valid && !ack_take) |=> irq_req_out)
        else $error("enabled pending request not forwarded");

    AST_NO_FWD: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !global_enable_in |=> !irq_req_out)
        else $error("request forwarded while globally disabled");

    AST_ACK: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (ack_take && !g0_set[irq_source_out]) |=>
            !group0_pending[$past(irq_source_out)] ##1 1'b1)
        else $error("acknowledge did not clear the pending bit");

    AST_LEVEL: assert property (
        @(posedge clk_in) disable iff (srst_in)
        irq_req_out |->
            ({group0_enable_high[irq_source_out], group0_enable_low[irq_source_out]}
             != IPE_LVL_OFF || $past(g0_clr) != RD_ZERO || $past(wr_g0_enh || wr_g0_enl)))
        else $error("forwarded request has no enable level");

    AST_SET_READ: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == ADDR_PP_SET) |=> (reg_rdata_out == RD_ZERO))
        else $error("set register did not read as zero");

    AST_PER_W1C: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_per_pend && (per_set & reg_wdata_in) == RD_ZERO) |=>
            ((peripheral_pending & $past(reg_wdata_in)) == RD_ZERO))
        else $error("write one did not clear peripheral pending");

    AST_G0_SETREG: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_g0_set |=>
            ((group0_pending & $past(reg_wdata_in)) == $past(reg_wdata_in)))
        else $error("group0 set write did not set pending");

    AST_PER_HW: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (|peripheral_req_in) |=>
            ((peripheral_pending & $past(peripheral_req_in)) == $past(peripheral_req_in)))
        else $error("peripheral request did not set its pending bit");

    AST_CMP_SEL: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (mux_select[MUX_COMPARATOR_BIT] && comparator_req_in) |=>
            port_pin_pending[MUX_COMPARATOR_BIT])
        else $error("selected comparator request did not set pending bit 7");

    AST_DBG_SEL: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (mux_select[MUX_DEBUGGER_BIT] && debugger_req_in) |=>
            port_pin_pending[MUX_DEBUGGER_BIT])
        else $error("selected debugger request did not set pending bit 0");

    // port-pin pending must not change in a cycle with no set and no clear
    AST_PP_QUIET: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (pp_set == RD_ZERO && pp_clr == RD_ZERO) |=> $stable(port_pin_pending))
        else $error("port-pin pending changed with no set or clear");

    // enable writes alone never create a pending bit
    AST_NO_SPURIOUS: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (g0_set == RD_ZERO) |=>
            ((group0_pending & ~$past(group0_pending)) == RD_ZERO))
        else $error("group0 pending bit rose with no set");

    AST_RD_IDLE: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !reg_rd_in |=> (reg_rdata_out == RD_ZERO))
        else $error("read data shown without a read strobe");

    AST_ACK_DROP: assert property (
        @(posedge clk_in) disable iff (srst_in)
        ack_take |=> !irq_req_out)
        else $error("request still shown the cycle after an acknowledge");

    AST_LEVEL_OUT: assert property (
        @(posedge clk_in) disable iff (srst_in)
        irq_req_out |-> (irq_level_out != IPE_LVL_OFF))
        else $error("request forwarded with a disabled level");

    // no disable here: this one looks at the reset itself, mid-run too
    AST_RESET: assert property (
        @(posedge clk_in)
        srst_in |=> (group0_pending == PEND_RST && port_pin_pending == PEND_RST &&
                     peripheral_pending == PEND_RST && group0_enable_high == EN_RST &&
                     group0_enable_low == EN_RST && !irq_req_out))
        else $error("registers not cleared by reset");

    COV_FWD: cover property (@(posedge clk_in) disable iff (srst_in)
        irq_req_out && irq_level_out == IPE_LVL_HIGH);
    COV_ACK: cover property (@(posedge clk_in) disable iff (srst_in)
        ack_take ##2 irq_req_out);
    COV_CMP: cover property (@(posedge clk_in) disable iff (srst_in)
        mux_select[MUX_COMPARATOR_BIT] && comparator_req_in);
    COV_POLL: cover property (@(posedge clk_in) disable iff (srst_in)
        !global_enable_in && reg_rd_in && reg_addr_in == ADDR_PER_PEND);

endmodule

// [verilog/ipe_edge_sync.sv]
`timescale 1ns/1ps
module ipe_edge_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] toggle_out
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;

    // meta is read only by sync; edges are found one stage later
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    // either edge counts as a toggle
    assign toggle_out = sync ^ prev;
endmodule

// [verilog/ipe_pkg.sv]
package ipe_pkg;

    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 24;
    localparam int SRC_W     = 3;
    localparam int LVL_W     = 2;

    localparam logic [ADDR_W-1:0] ADDR_G0_PEND  = 24'hffe030;
    localparam logic [ADDR_W-1:0] ADDR_G0_SET   = 24'hffe031;
    localparam logic [ADDR_W-1:0] ADDR_G0_ENH   = 24'hffe032;
    localparam logic [ADDR_W-1:0] ADDR_G0_ENL   = 24'hffe033;
    localparam logic [ADDR_W-1:0] ADDR_PP_PEND  = 24'hffe034;
    localparam logic [ADDR_W-1:0] ADDR_PP_SET   = 24'hffe035;
    localparam logic [ADDR_W-1:0] ADDR_PER_PEND = 24'hffe038;
    localparam logic [ADDR_W-1:0] ADDR_PER_SET  = 24'hffe039;
    localparam logic [ADDR_W-1:0] ADDR_MUX_SEL  = 24'hffe03c;

    localparam logic [DATA_W-1:0] PEND_RST = 8'h00;
    localparam logic [DATA_W-1:0] EN_RST   = 8'h00;
    localparam logic [DATA_W-1:0] MUX_RST  = 8'h00;
    localparam logic [DATA_W-1:0] RD_ZERO  = 8'h00;

    // positions in the mux select register and in the port-pin pending register
    localparam int MUX_DEBUGGER_BIT   = 0;
    localparam int MUX_COMPARATOR_BIT = 7;

    typedef enum logic [LVL_W-1:0] {
        IPE_LVL_OFF  = 2'b00,
        IPE_LVL_LOW  = 2'b01,
        IPE_LVL_NOM  = 2'b10,
        IPE_LVL_HIGH = 2'b11
    } ipe_level_t;

    // a set in the same cycle as a clear wins, so no event is lost
    function automatic logic [DATA_W-1:0] ipe_next_pending(
        input logic [DATA_W-1:0] cur,
        input logic [DATA_W-1:0] set,
        input logic [DATA_W-1:0] clr
    );
        return (cur & ~clr) | set;
    endfunction

endpackage

// [verilog/ipe_prio_pick.sv]
`timescale 1ns/1ps
module ipe_prio_pick
    import ipe_pkg::*;
#(
    parameter int N  = 8,
    parameter int IW = $clog2(N)
) (
    input  wire logic [N-1:0]     pend_in,
    input  wire logic [N-1:0]     enh_in,
    input  wire logic [N-1:0]     enl_in,
    output logic                  valid_out,
    output logic [IW-1:0]         idx_out,
    output logic [LVL_W-1:0]      level_out
);
    logic [LVL_W-1:0] lvl [N];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_lvl
            assign lvl[g] = pend_in[g] ? {enh_in[g], enl_in[g]} : IPE_LVL_OFF;
        end
    endgenerate

    // ascending scan with >= lets the higher bit win a tie
    always_comb begin
        level_out = IPE_LVL_OFF;
        idx_out   = '0;
        for (int i = 0; i < N; i++) begin
            if (lvl[i] != IPE_LVL_OFF && lvl[i] >= level_out) begin
                level_out = lvl[i];
                idx_out   = i[IW-1:0];
            end
        end
    end

    assign valid_out = (level_out != IPE_LVL_OFF);
endmodule
